// *** rtl/fa_map.svh ***
// Constants for the frequency arrival flag block
`ifndef FA_MAP_SVH
`define FA_MAP_SVH

// Frequency words are unsigned, 0.01 Hz per count
`define FA_FREQ_W        16
// Turn-on anticipation, 1.5 Hz
`define FA_ON_LEAD       16'h0096
// Turn-off delay, 0.5 Hz
`define FA_OFF_LAG       16'h0032
// Output function codes
`define FA_FC_CONST      8'h01
`define FA_FC_OVER_A     8'h02
`define FA_FC_SET_A      8'h03
`define FA_FC_OVER_B     8'h18
`define FA_FC_SET_B      8'h19
// Number of output terminals
`define FA_TERMS         3

`endif

// *** rtl/fa_pkg.sv ***
// Types for the frequency arrival flag block
`include "fa_map.svh"

package fa_pkg;

    // Threshold pair for the over-frequency flag plus the set-frequency target
    typedef struct packed {
        logic [`FA_FREQ_W-1:0] accel;
        logic [`FA_FREQ_W-1:0] decel;
        logic [`FA_FREQ_W-1:0] arrive;
    } fa_thr_t;

    // Drive state as seen by the comparators
    typedef struct packed {
        logic                  run;
        logic                  accel;
        logic                  decel;
        logic [`FA_FREQ_W-1:0] freq;
        logic [`FA_FREQ_W-1:0] set_freq;
    } fa_drive_t;

    // The five arrival flags
    typedef struct packed {
        logic const_speed_arrival;
        logic over_freq_arrival_a;
        logic set_freq_arrival_a;
        logic over_freq_arrival_b;
        logic set_freq_arrival_b;
    } fa_flags_t;

    typedef logic [`FA_TERMS-1:0][7:0] fa_sel_t;

    // Whole module state
    typedef struct packed {
        fa_flags_t              flags;
        logic [`FA_TERMS-1:0]   term;
    } fa_state_t;

endpackage

// *** rtl/fa_flags.sv ***
// Frequency arrival flags with hysteresis and terminal routing
`timescale 1ns/1ps
`default_nettype none
`include "fa_map.svh"

module fa_flags
    import fa_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_update,
    input  wire fa_drive_t            i_drive,
    input  wire fa_thr_t              i_thr_a,
    input  wire fa_thr_t              i_thr_b,
    input  wire fa_sel_t              i_term_sel,
    output var  fa_flags_t            o_flags,
    output var  logic [`FA_TERMS-1:0] o_term
);

    //--------------------------------------------------------------
    // Comparison helpers
    //--------------------------------------------------------------

    // Distance between two frequencies, never wraps
    function automatic logic [`FA_FREQ_W-1:0] fa_dist(
        input logic [`FA_FREQ_W-1:0] a,
        input logic [`FA_FREQ_W-1:0] b
    );
        fa_dist = (a > b) ? a - b : b - a;
    endfunction

    // True when f plus an offset reaches the threshold; widened to avoid wrap
    function automatic logic fa_reach(
        input logic [`FA_FREQ_W-1:0] f,
        input logic [`FA_FREQ_W-1:0] ofs,
        input logic [`FA_FREQ_W-1:0] thr
    );
        fa_reach = ({1'b0, f} + {1'b0, ofs}) >= {1'b0, thr};
    endfunction

    // Equality flag: narrow window to turn on, wider window to stay on
    function automatic logic fa_set_next(
        input logic                  cur,
        input fa_drive_t             d,
        input logic [`FA_FREQ_W-1:0] thr
    );
        logic [`FA_FREQ_W:0] win;
        win = cur ? {1'b0, `FA_ON_LEAD} + {1'b0, `FA_OFF_LAG} : {1'b0, `FA_ON_LEAD};
        if (!d.run || d.accel || d.decel) begin
            fa_set_next = 1'b0;
        end else begin
            fa_set_next = {1'b0, fa_dist(d.freq, thr)} <= win;
        end
    endfunction

    // Over-frequency flag with directional thresholds
    function automatic logic fa_over_next(
        input logic      cur,
        input fa_drive_t d,
        input fa_thr_t   t
    );
        logic [`FA_FREQ_W-1:0] thr;
        thr = d.decel ? t.decel : t.accel;
        if (!d.run) begin
            fa_over_next = 1'b0;
        end else if (cur) begin
            // Held until 0.5 Hz below the decel threshold
            fa_over_next = fa_reach(d.freq, `FA_OFF_LAG, t.decel);
        end else begin
            fa_over_next = fa_reach(d.freq, `FA_ON_LEAD, thr);
        end
    endfunction

    // Route one flag to a terminal by its function code
    function automatic logic fa_pick(
        input logic [7:0] code,
        input fa_flags_t  f
    );
        case (code)
            `FA_FC_CONST:  fa_pick = f.const_speed_arrival;
            `FA_FC_OVER_A: fa_pick = f.over_freq_arrival_a;
            `FA_FC_SET_A:  fa_pick = f.set_freq_arrival_a;
            `FA_FC_OVER_B: fa_pick = f.over_freq_arrival_b;
            `FA_FC_SET_B:  fa_pick = f.set_freq_arrival_b;
            default:       fa_pick = 1'b0;
        endcase
    endfunction

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------

    fa_state_t st;
    fa_state_t next_st;

    // Flags move only on an update strobe; terminals follow every cycle
    always_comb begin
        next_st = st;
        if (i_update) begin
            next_st.flags.const_speed_arrival =
                fa_set_next(st.flags.const_speed_arrival, i_drive, i_drive.set_freq);
            next_st.flags.over_freq_arrival_a =
                fa_over_next(st.flags.over_freq_arrival_a, i_drive, i_thr_a);
            next_st.flags.set_freq_arrival_a =
                fa_set_next(st.flags.set_freq_arrival_a, i_drive, i_thr_a.arrive);
            next_st.flags.over_freq_arrival_b =
                fa_over_next(st.flags.over_freq_arrival_b, i_drive, i_thr_b);
            next_st.flags.set_freq_arrival_b =
                fa_set_next(st.flags.set_freq_arrival_b, i_drive, i_thr_b.arrive);
        end
        // Each terminal decoded on its own, so any mix may be active
        for (int k = 0; k < `FA_TERMS; k++) begin
            next_st.term[k] = fa_pick(i_term_sel[k], next_st.flags);
        end
    end

    // Synchronous reset clears every flag
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_flags = st.flags;
    assign o_term  = st.term;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------

    default clocking fa_cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    logic ramp;
    assign ramp = i_drive.accel | i_drive.decel;

    chk_cs_on_hold: assert property (
        i_update && i_drive.run && !ramp && i_drive.freq == i_drive.set_freq
        |=> o_flags.const_speed_arrival)
        else $error("const speed flag missing at set frequency");

    chk_cs_ramp_off: assert property (
        i_update && (!i_drive.run || ramp) |=> !o_flags.const_speed_arrival)
        else $error("const speed flag set while stopped or ramping");

    chk_over_lead_on: assert property (
        i_update && i_drive.run && !i_drive.decel
        && fa_reach(i_drive.freq, `FA_ON_LEAD, i_thr_a.accel)
        |=> o_flags.over_freq_arrival_a)
        else $error("over freq flag did not turn on 1.5 Hz early");

    chk_over_below_off: assert property (
        i_update && !o_flags.over_freq_arrival_a && i_drive.accel
        && !fa_reach(i_drive.freq, `FA_ON_LEAD, i_thr_a.accel)
        |=> !o_flags.over_freq_arrival_a)
        else $error("over freq flag on before accel threshold");

    chk_over_lag_hold: assert property (
        i_update && i_drive.run && o_flags.over_freq_arrival_a
        && fa_reach(i_drive.freq, `FA_OFF_LAG, i_thr_a.decel)
        |=> o_flags.over_freq_arrival_a)
        else $error("over freq flag dropped before 0.5 Hz lag");

    chk_over_b_stop: assert property (
        i_update && !i_drive.run |=> !o_flags.over_freq_arrival_b)
        else $error("second over freq flag set while stopped");

    chk_set_a_ramp: assert property (
        i_update && ramp |=> !o_flags.set_freq_arrival_a)
        else $error("set freq flag set during ramp");

    chk_set_b_equal: assert property (
        i_update && i_drive.run && !ramp && i_drive.freq == i_thr_b.arrive
        |=> o_flags.set_freq_arrival_b)
        else $error("second set freq flag missing at threshold");

    chk_flags_stable: assert property (
        !i_update |=> $stable(o_flags))
        else $error("flags moved without an update");

    chk_term_route: assert property (
        ##1 o_term[0] == fa_pick($past(i_term_sel[0]), o_flags)
        && o_term[1] == fa_pick($past(i_term_sel[1]), o_flags))
        else $error("terminal does not carry its selected flag");

    chk_reset_clear: assert property (
        disable iff (1'b0) !i_rst_n |=> o_flags == '0 && o_term == '0)
        else $error("flags not cleared by reset");

    cov_const_on:  cover property (o_flags.const_speed_arrival);
    cov_over_hyst: cover property (o_flags.over_freq_arrival_a && i_drive.decel);
    cov_both_b:    cover property (o_flags.over_freq_arrival_b && o_flags.set_freq_arrival_b);
    cov_two_terms: cover property (o_term[0] && o_term[1]);

endmodule
`default_nettype wire

// *** testbench/fa_term_watch.sv ***
// Model of the equipment watching one arrival terminal
`timescale 1ns/1ps
`default_nettype none
module fa_term_watch (
    input  wire logic       i_mclk,
    input  wire logic       i_clr,
    input  wire logic       i_term,
    output var  logic [7:0] o_rises
);
    logic prev;
    // Count turn-on edges; a chattering flag shows up as extra counts
    always_ff @(posedge i_mclk) begin
        prev <= i_term;
        if (i_clr)
            o_rises <= 8'h00;
        else if (i_term && !prev)
            o_rises <= o_rises + 8'h01;
    end
endmodule
`default_nettype wire

// *** testbench/test_fa_flags.sv ***
// Self-checking bench for the frequency arrival flag block
`timescale 1ns/1ps
`default_nettype none
`include "fa_map.svh"
module test_fa_flags;
    import fa_pkg::*;
    logic                 mclk;
    logic                 rst_n;
    logic                 upd_s;
    logic                 clr;
    fa_drive_t            drv;
    fa_thr_t              thr_a;
    fa_thr_t              thr_b;
    fa_sel_t              sel;
    fa_flags_t            flags;
    logic [`FA_TERMS-1:0] term;
    logic [7:0]           rises;
    int                   num_errors;
    int                   check_count;

    fa_flags DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_update(upd_s), .i_drive(drv),
        .i_thr_a(thr_a), .i_thr_b(thr_b), .i_term_sel(sel), .o_flags(flags), .o_term(term));
    fa_term_watch watch (.i_mclk(mclk), .i_clr(clr), .i_term(term[0]), .o_rises(rises));

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_flags(input fa_flags_t exp);
        check_count++;
        if (flags !== exp) begin
            num_errors++;
            $display("Error at %0t: flags %b expected %b", $time, flags, exp);
        end
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    // One update strobe, then two idle cycles; terminals register in the same cycle as the flags
    task automatic upd(input logic [2:0] rad, input logic [`FA_FREQ_W-1:0] f);
        drv.run = rad[2];
        drv.accel = rad[1];
        drv.decel = rad[0];
        drv.freq = f;
        upd_s = 1'b1;
        @(negedge mclk);
        upd_s = 1'b0;
        repeat (2) @(negedge mclk);
    endtask

    task automatic t_const();
        upd(3'b100, 16'h12F2);
        chk_flags(5'b11010);
        upd(3'b100, 16'h1450);
        chk_flags(5'b11010);
        upd(3'b100, 16'h1451);
        chk_flags(5'b01010);
        upd(3'b100, 16'h1388);
        chk_flags(5'b11010);
        upd(3'b110, 16'h1388);
        chk_flags(5'b01010);
        upd(3'b000, 16'h1388);
        chk_flags(5'b00000);
        // Input change without a strobe must not move the flags
        drv.run = 1'b1;
        repeat (3) @(negedge mclk);
        chk_flags(5'b00000);
    endtask

    task automatic t_over();
        upd(3'b110, 16'h0B21);
        chk_flags(5'b00000);
        upd(3'b110, 16'h0B22);
        chk_flags(5'b01000);
        upd(3'b101, 16'h079E);
        chk_flags(5'b01000);
        upd(3'b101, 16'h079D);
        chk_flags(5'b00000);
        upd(3'b101, 16'h0739);
        chk_flags(5'b00000);
        upd(3'b110, 16'h0F0A);
        chk_flags(5'b01010);
        upd(3'b101, 16'h0D7A);
        chk_flags(5'b01010);
        upd(3'b101, 16'h0D79);
        chk_flags(5'b01000);
        upd(3'b000, 16'h0D79);
        chk_flags(5'b00000);
    endtask

    task automatic t_set();
        upd(3'b100, 16'h03E8);
        chk_flags(5'b00100);
        upd(3'b101, 16'h03E8);
        chk_flags(5'b00000);
        upd(3'b100, 16'h0960);
        chk_flags(5'b00001);
        upd(3'b110, 16'h0960);
        chk_flags(5'b00000);
        // Exact hit on the second target, starting from off
        upd(3'b100, 16'h09C4);
        chk_flags(5'b00001);
    endtask

    task automatic t_term();
        upd(3'b100, 16'h1388);
        chk_val({5'b0, term}, 8'h03);
        sel[2] = 8'h18;
        repeat (2) @(negedge mclk);
        chk_val({5'b0, term}, 8'h07);
        sel[2] = 8'h7F;
        repeat (2) @(negedge mclk);
        chk_val({5'b0, term}, 8'h03);
        // First set-frequency flag routed by its own code
        sel[2] = 8'h03;
        upd(3'b100, 16'h03E8);
        chk_val({5'b0, term}, 8'h04);
    endtask

    // Reset in mid-run must clear flags that are on
    task automatic t_reset();
        upd(3'b100, 16'h1388);
        chk_flags(5'b11010);
        rst_n = 1'b0;
        @(negedge mclk);
        chk_flags(5'b00000);
        chk_val({5'b0, term}, 8'h00);
        rst_n = 1'b1;
        @(negedge mclk);
    endtask

    // Frequency hovering around the set point must give one turn-on only
    task automatic t_chatter();
        logic [15:0] hov [5] = '{16'h12F2, 16'h1450, 16'h12C0, 16'h1450, 16'h12F2};
        upd(3'b000, 16'h1388);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        foreach (hov[i]) upd(3'b100, hov[i]);
        chk_val(rises, 8'h01);
    endtask

    initial begin
        num_errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        upd_s = 1'b0;
        clr = 1'b0;
        drv = '0;
        drv.set_freq = 16'h1388;
        thr_a = {16'h0BB8, 16'h07D0, 16'h03E8};
        thr_b = {16'h0FA0, 16'h0DAC, 16'h09C4};
        sel = {8'h19, 8'h02, 8'h01};
        repeat (4) @(negedge mclk);
        chk_flags(5'b00000);
        rst_n = 1'b1;
        @(negedge mclk);
        t_const();
        t_over();
        t_set();
        t_term();
        t_reset();
        t_chatter();
        tally_and_finish();
    end

    // Watchdog, far beyond the roughly 100 cycles the tests need
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
